// file: bpq_pkg.sv
package bpq_pkg;
    // ---------------------------------------------------------------
    // Transfer widths
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {BPQ_BYTE, BPQ_DOUBLE, BPQ_QUAD} bpq_width_t;

    // ---------------------------------------------------------------
    // Address modifier codes per address size (values chosen locally)
    // ---------------------------------------------------------------
    localparam logic [5:0] BPQ_AM_SHORT = 6'h01;
    localparam logic [5:0] BPQ_AM_STD = 6'h02;
    localparam logic [5:0] BPQ_AM_EXT = 6'h03;

    // Address bits decoded for each address size
    localparam logic [31:0] BPQ_MASK_A16 = 32'h0000_FFFF;
    localparam logic [31:0] BPQ_MASK_A24 = 32'h00FF_FFFF;
    localparam logic [31:0] BPQ_MASK_A32 = 32'hFFFF_FFFF;

    // Level of undriven lines held by the terminators
    localparam logic [31:0] BPQ_DATA_IDLE = 32'hFFFF_FFFF;

    // All-zero word: reset value of the read data and the access address
    localparam logic [31:0] BPQ_ZERO = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Backplane lines as seen at a board's receivers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic asN;
        logic ds0N;
        logic ds1N;
        logic lwordN;
        logic writeN;
        logic iackN;
        logic dtackN;
        logic [5:0] am;
        logic [31:1] addr;
        logic [31:0] data;
    } bpq_pins_t;

    // Idle level of all lines after reset
    localparam bpq_pins_t BPQ_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b1, 1'b1, 6'h3F, 31'h7FFF_FFFF, 32'hFFFF_FFFF};
endpackage

// file: bpq_bus_if.sv
interface bpq_bus_if;
    import bpq_pkg::*;
    // ---------------------------------------------------------------
    // Master drivers
    // ---------------------------------------------------------------
    logic mAsN, mDs0N, mDs1N, mLwordN, mWriteN;
    logic [5:0] mAm;
    logic [31:1] mAddr;
    logic mIackO, mIackOe;
    logic [31:0] mDataO;
    logic mDataOe;
    // ---------------------------------------------------------------
    // Slave drivers
    // ---------------------------------------------------------------
    logic [31:0] sDataO;
    logic sDataOe;
    logic sDtackOe;
    // Resolved lines: undriven lines float high through the terminators
    logic iackN;
    logic dtackN;
    logic [31:0] data;
    bpq_pins_t pins;
    assign iackN = mIackOe ? mIackO : 1'b1;
    assign dtackN = ~sDtackOe;
    assign data = mDataOe ? mDataO : (sDataOe ? sDataO : BPQ_DATA_IDLE);
    assign pins = '{mAsN, mDs0N, mDs1N, mLwordN, mWriteN, iackN, dtackN,
        mAm, mAddr, data};
    modport master (output mAsN, mDs0N, mDs1N, mLwordN, mWriteN, mAm, mAddr,
        mIackO, mIackOe, mDataO, mDataOe, input pins);
    modport slave (output sDataO, sDataOe, sDtackOe, input pins);
endinterface

// file: bpq_master.sv
module bpq_master import bpq_pkg::*; #(
    parameter bit CAP_BYTE = 1'b1, // Wider masters keep byte cycles
    parameter bit CAP_DOUBLE = 1'b1,
    parameter bit CAP_QUAD = 1'b1,
    parameter bit DRIVE_IACK = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Backplane
    bpq_bus_if.master bus,
    // Request
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire bpq_width_t reqWidth,
    input wire logic [31:0] reqAddr,
    input wire logic [5:0] reqAm,
    input wire logic [31:0] reqData,
    output logic reqReady,
    // Answer
    output logic rspDone,
    output logic rspErr,
    output logic [31:0] rspData
);
    // ---------------------------------------------------------------
    // Capability check
    // ---------------------------------------------------------------
    if (!(CAP_BYTE || CAP_DOUBLE || CAP_QUAD)) begin : gChk
        $error("master needs at least one width");
    end

    typedef enum logic [1:0] {M_IDLE, M_ADDR, M_STROBE, M_RELEASE} mst_state_t;

    typedef struct packed {
        mst_state_t st;
        bpq_pins_t p1; // First sync stage
        bpq_pins_t p2; // Second sync stage
        logic asN, ds0N, ds1N, lwordN, writeN;
        logic [5:0] am;
        logic [31:1] addr;
        logic iackOe;
        logic [31:0] dataO;
        logic dataOe;
        bpq_width_t wid;
        logic oddByte; // Byte cycle targets an odd position
        logic ready, done, err;
        logic [31:0] rdData;
    } mst_t;

    mst_t q, d;
    logic legal; // Request fits capability and alignment

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.p1 = bus.pins;
        d.p2 = q.p1;
        d.done = 1'b0;
        d.err = 1'b0;
        legal = 1'b0;
        case (q.st)
            M_IDLE: begin
                case (reqWidth)
                    BPQ_BYTE: legal = CAP_BYTE;
                    BPQ_DOUBLE: legal = CAP_DOUBLE && !reqAddr[0];
                    BPQ_QUAD: legal = CAP_QUAD && reqAddr[1:0] == 2'b00;
                    default: legal = 1'b0;
                endcase
                if (reqValid && q.ready) begin
                    if (!legal) begin
                        d.err = 1'b1;
                    end else begin
                        // Broadcast address with the acknowledge line high
                        d.ready = 1'b0;
                        d.wid = reqWidth;
                        d.addr = reqAddr[31:1];
                        d.am = reqAm; // Any address size passes through
                        d.oddByte = reqAddr[0];
                        d.writeN = ~reqWrite;
                        d.lwordN = reqWidth != BPQ_QUAD;
                        d.iackOe = DRIVE_IACK;
                        d.dataOe = reqWrite;
                        d.ds0N = 1'b1;
                        d.ds1N = 1'b1;
                        case (reqWidth)
                            BPQ_BYTE: begin
                                // Odd bytes ride the lowest lane
                                d.dataO = reqAddr[0] ? {24'hFF_FFFF, reqData[7:0]}
                                    : {16'hFFFF, reqData[7:0], 8'hFF};
                            end
                            BPQ_DOUBLE: d.dataO = {16'hFFFF, reqData[15:0]};
                            default: d.dataO = reqData;
                        endcase
                        d.st = M_ADDR;
                    end
                end
            end
            M_ADDR: begin
                // Strobes one cycle after the address
                d.asN = 1'b0;
                d.ds0N = q.wid == BPQ_BYTE && !q.addr[1] ? 1'b1 : 1'b0;
                d.ds1N = q.wid == BPQ_BYTE && q.addr[1] ? 1'b1 : 1'b0;
                if (q.wid == BPQ_BYTE) begin
                    d.ds0N = ~reqAddrOdd(q);
                    d.ds1N = reqAddrOdd(q);
                end
                d.st = M_STROBE;
            end
            M_STROBE: begin
                if (!q.p2.dtackN) begin
                    case (q.wid)
                        BPQ_BYTE: d.rdData = {24'h00_0000,
                            reqAddrOdd(q) ? q.p2.data[7:0] : q.p2.data[15:8]};
                        BPQ_DOUBLE: d.rdData = {16'h0000, q.p2.data[15:0]};
                        default: d.rdData = q.p2.data;
                    endcase
                    d.asN = 1'b1;
                    d.ds0N = 1'b1;
                    d.ds1N = 1'b1;
                    d.dataOe = 1'b0;
                    d.st = M_RELEASE;
                end
            end
            M_RELEASE: begin
                // Finish once the slave lets go of its acknowledge
                if (q.p2.dtackN) begin
                    d.iackOe = 1'b0;
                    d.ready = 1'b1;
                    d.done = 1'b1;
                    d.st = M_IDLE;
                end
            end
            default: d.st = M_IDLE;
        endcase
    end

    // Byte position is odd; latched from the lowest request address bit
    function automatic logic reqAddrOdd(input mst_t s);
        return s.oddByte;
    endfunction

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '{st: M_IDLE, p1: BPQ_PINS_IDLE, p2: BPQ_PINS_IDLE,
                asN: 1'b1, ds0N: 1'b1, ds1N: 1'b1, lwordN: 1'b1, writeN: 1'b1,
                am: 6'h3F, addr: 31'h7FFF_FFFF, iackOe: 1'b0,
                dataO: BPQ_DATA_IDLE, dataOe: 1'b0, wid: BPQ_BYTE, oddByte: 1'b0,
                ready: 1'b1, done: 1'b0, err: 1'b0, rdData: BPQ_ZERO};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register, except the acknowledge level tied high
    assign bus.mAsN = q.asN;
    assign bus.mDs0N = q.ds0N;
    assign bus.mDs1N = q.ds1N;
    assign bus.mLwordN = q.lwordN;
    assign bus.mWriteN = q.writeN;
    assign bus.mAm = q.am;
    assign bus.mAddr = q.addr;
    assign bus.mIackO = 1'b1;
    assign bus.mIackOe = q.iackOe;
    assign bus.mDataO = q.dataO;
    assign bus.mDataOe = q.dataOe;
    assign reqReady = q.ready;
    assign rspDone = q.done;
    assign rspErr = q.err;
    assign rspData = q.rdData;
endmodule // bpq_master

// file: bpq_slave.sv
module bpq_slave import bpq_pkg::*; #(
    parameter bit CAP_ODD_ONLY = 1'b0,
    parameter bit CAP_EVEN_ODD = 1'b1,
    parameter bit CAP_D16 = 1'b1,
    parameter bit CAP_D32 = 1'b1,
    parameter logic [5:0] AM_ACCEPT = BPQ_AM_EXT,
    parameter logic [31:0] BASE = 32'h0000_0000,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Backplane
    bpq_bus_if.slave bus,
    // Access report
    output logic accPulse,
    output logic accWrite,
    output logic [31:0] accAddr,
    output logic iackPulse,
    output logic rejPulse
);
    localparam int IDXW = $clog2(DEPTH);

    // ---------------------------------------------------------------
    // Capability check
    // ---------------------------------------------------------------
    // Odd-only excludes every other width
    if (CAP_ODD_ONLY && (CAP_EVEN_ODD || CAP_D16 || CAP_D32)) begin : gOdd
        $error("odd-only slave cannot accept other widths");
    end
    if (!(CAP_ODD_ONLY || CAP_EVEN_ODD || CAP_D16 || CAP_D32)) begin : gNone
        $error("slave needs at least one width");
    end
    if (DEPTH < 2 || (1 << IDXW) != DEPTH) begin : gDepth
        $error("DEPTH must be a power of two of at least 2");
    end

    typedef enum logic [1:0] {S_IDLE, S_ACK, S_WAIT} slv_state_t;

    typedef struct packed {
        slv_state_t st;
        bpq_pins_t p1; // First sync stage
        bpq_pins_t p2; // Second sync stage
        logic [31:0] dataO;
        logic dataOe;
        logic dtackOe;
        logic [DEPTH-1:0][31:0] mem;
        logic acc, accW, iack, rej;
        logic [31:0] accA;
    } slv_t;

    slv_t q, d;
    bpq_pins_t p; // Synchronised lines
    logic strobe; // Address and a data strobe low
    logic isQuad, isDouble, isByte;
    logic [1:0] pos; // Byte position within the longword
    logic widthOk; // Width within declared capability
    logic hit; // Address modifier and address decode
    logic [31:0] mask;
    logic [31:0] full;
    logic [IDXW-1:0] idx;

    // ---------------------------------------------------------------
    // Cycle decode
    // ---------------------------------------------------------------
    always_comb begin
        p = q.p2;
        strobe = !p.asN && (!p.ds0N || !p.ds1N);
        isQuad = !p.ds0N && !p.ds1N && !p.lwordN && !p.addr[1];
        isDouble = !p.ds0N && !p.ds1N && p.lwordN;
        isByte = (p.ds0N != p.ds1N) && p.lwordN;
        // Data strobe 0 alone selects the odd byte
        pos = {p.addr[1], p.ds1N};
        widthOk = (isQuad && CAP_D32)
            || (isDouble && CAP_D16)
            || (isByte && CAP_EVEN_ODD)
            || (isByte && CAP_ODD_ONLY && pos[0]);
        case (p.am)
            BPQ_AM_SHORT: mask = BPQ_MASK_A16;
            BPQ_AM_STD: mask = BPQ_MASK_A24;
            default: mask = BPQ_MASK_A32;
        endcase
        full = {p.addr, 1'b0} & mask;
        hit = p.am == AM_ACCEPT && full[31:IDXW+2] == BASE[31:IDXW+2];
        idx = full[IDXW+1:2];
    end

    // Merge bus data into a stored word by lane
    function automatic logic [31:0] wrLanes(input logic [31:0] w,
                                            input logic [31:0] v,
                                            input logic qd, input logic db,
                                            input logic [1:0] ps);
        logic [31:0] r;
        r = w;
        if (qd) begin
            r = v;
        end else if (db) begin
            if (ps[1]) begin
                r[15:0] = v[15:0];
            end else begin
                r[31:16] = v[15:0];
            end
        end else begin
            // Odd bytes on the lowest lane, even on the next
            r[8*(3-ps) +: 8] = ps[0] ? v[7:0] : v[15:8];
        end
        return r;
    endfunction

    // Place a stored word onto the bus lanes
    function automatic logic [31:0] rdLanes(input logic [31:0] w,
                                            input logic qd, input logic db,
                                            input logic [1:0] ps);
        logic [31:0] r;
        r = BPQ_ZERO;
        if (qd) begin
            r = w;
        end else if (db) begin
            r[15:0] = ps[1] ? w[15:0] : w[31:16];
        end else if (ps[0]) begin
            r[7:0] = w[8*(3-ps) +: 8];
        end else begin
            r[15:8] = w[8*(3-ps) +: 8];
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.p1 = bus.pins;
        d.p2 = q.p1;
        d.acc = 1'b0;
        d.iack = 1'b0;
        d.rej = 1'b0;
        case (q.st)
            S_IDLE: begin
                if (strobe) begin
                    if (!p.iackN) begin
                        // Interrupt acknowledge: stay off the bus
                        d.iack = 1'b1;
                        d.st = S_WAIT;
                    end else if (hit && widthOk) begin
                        // Accepted cycle
                        d.acc = 1'b1;
                        d.accW = !p.writeN;
                        d.accA = full;
                        if (!p.writeN) begin
                            d.mem[idx] = wrLanes(q.mem[idx], p.data, isQuad,
                                isDouble, pos);
                        end else begin
                            d.dataO = rdLanes(q.mem[idx], isQuad, isDouble, pos);
                            d.dataOe = 1'b1;
                        end
                        d.dtackOe = 1'b1;
                        d.st = S_ACK;
                    end else begin
                        // Not ours or unsupported: no acknowledge
                        d.rej = hit;
                        d.st = S_WAIT;
                    end
                end
            end
            S_ACK: begin
                // Release lines when both strobes rise
                if (p.ds0N && p.ds1N) begin
                    d.dtackOe = 1'b0;
                    d.dataOe = 1'b0;
                    d.st = S_IDLE;
                end
            end
            S_WAIT: begin
                // Sit out the foreign cycle
                if (p.ds0N && p.ds1N) begin
                    d.st = S_IDLE;
                end
            end
            default: d.st = S_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '{st: S_IDLE, p1: BPQ_PINS_IDLE, p2: BPQ_PINS_IDLE,
                dataO: BPQ_DATA_IDLE, dataOe: 1'b0, dtackOe: 1'b0,
                mem: '0, acc: 1'b0, accW: 1'b0, iack: 1'b0, rej: 1'b0,
                accA: BPQ_ZERO};
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs straight from the state register
    // ---------------------------------------------------------------
    assign bus.sDataO = q.dataO;
    assign bus.sDataOe = q.dataOe;
    assign bus.sDtackOe = q.dtackOe;
    assign accPulse = q.acc;
    assign accWrite = q.accW;
    assign accAddr = q.accA;
    assign iackPulse = q.iack;
    assign rejPulse = q.rej;
endmodule // bpq_slave

// file: bpq_bus_assertions.sv
module bpq_bus_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Master drivers
    input wire logic mAsN,
    input wire logic mDs0N,
    input wire logic mDs1N,
    input wire logic mLwordN,
    input wire logic mWriteN,
    input wire logic [31:1] mAddr,
    input wire logic mIackO,
    input wire logic mIackOe,
    input wire logic mDataOe,
    // Slave drivers and resolved lines
    input wire logic sDataOe,
    input wire logic sDtackOe,
    input wire logic iackN,
    input wire logic dtackN
);
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------------
    // Steps of a cycle
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // Address and a data strobe both low
    wire logic strobeLow = !mAsN && !(mDs0N && mDs1N);
    sequence sAck;
        !dtackN;
    endsequence
    sequence sStrobeRise;
        $rose(strobeLow);
    endsequence
    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_iack_high_addr: assert property (!mAsN |-> iackN)
        else $error("interrupt acknowledge line low during address");
    // The bench's master drives the line itself instead of leaving it to the terminator
    a_iack_drive_high: assert property (!mAsN |-> mIackOe && mIackO)
        else $error("acknowledge line not driven high during address");
    a_no_answer_iack: assert property (!iackN |-> !sDtackOe && !sDataOe)
        else $error("slave drove the bus in an acknowledge cycle");
    a_ack_needs_strobe: assert property ($rose(sDtackOe) |-> $past(strobeLow, 2))
        else $error("acknowledge without a strobed cycle");
    a_ack_bounded: assert property (sStrobeRise |-> ##[1:8] sAck)
        else $error("supported cycle not acknowledged in time");
    a_strobe_hold: assert property (strobeLow && dtackN |=> strobeLow)
        else $error("strobes released before acknowledge");
    a_quad_aligned: assert property (strobeLow && !mLwordN |-> !mAddr[1] && !mDs0N && !mDs1N)
        else $error("quad cycle with bad lanes or alignment");
    a_read_drive_only: assert property (sDataOe |-> mWriteN && !mDataOe)
        else $error("slave drove data on a write");
    a_release_after: assert property ($fell(sDtackOe) |-> $past(mDs0N) && $past(mDs1N))
        else $error("acknowledge released while strobed");
endmodule // bpq_bus_assertions

// file: tb.sv
module tb import bpq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic clock, resetn, reqValid, reqWrite, reqReady, rspDone, rspErr;
    bpq_width_t reqWidth;
    logic [31:0] reqAddr, reqData, rspData, rnd, snapData;
    logic [5:0] reqAm;
    logic [7:0] mem [64]; // Byte image of the slave memory
    logic [1:0] snapDs; // Strobes seen at acknowledge
    logic snapLw, snapA1, oddIack, oddRej, sawIack, sawRej;
    int errTotal, cmpCount, cycles, i;
    bpq_bus_if bus ();
    bpq_bus_if bus2 (); // Odd-only slave, driven by the bench
    // ---------------------------------------------------------------
    // Design ends and checker
    // ---------------------------------------------------------------
    bpq_master bpq_master_i (.clock(clock), .resetn(resetn), .bus(bus.master),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqWidth(reqWidth), .reqAddr(reqAddr),
        .reqAm(reqAm), .reqData(reqData), .reqReady(reqReady), .rspDone(rspDone),
        .rspErr(rspErr), .rspData(rspData));
    bpq_slave bpq_slave_i (.clock(clock), .resetn(resetn), .bus(bus.slave), .accPulse(),
        .accWrite(), .accAddr(), .iackPulse(), .rejPulse());
    bpq_slave #(.CAP_ODD_ONLY(1'b1), .CAP_EVEN_ODD(1'b0), .CAP_D16(1'b0), .CAP_D32(1'b0))
        bpq_slave_odd_i (.clock(clock), .resetn(resetn), .bus(bus2.slave), .accPulse(),
        .accWrite(), .accAddr(), .iackPulse(oddIack), .rejPulse(oddRej));
    bpq_bus_assertions bpq_bus_assertions_i (.clock(clock), .resetn(resetn),
        .mAsN(bus.mAsN), .mDs0N(bus.mDs0N), .mDs1N(bus.mDs1N), .mLwordN(bus.mLwordN),
        .mWriteN(bus.mWriteN), .mAddr(bus.mAddr), .mIackO(bus.mIackO),
        .mIackOe(bus.mIackOe), .mDataOe(bus.mDataOe), .sDataOe(bus.sDataOe),
        .sDtackOe(bus.sDtackOe), .iackN(bus.iackN), .dtackN(bus.dtackN));
    // ---------------------------------------------------------------
    // Clock, monitors and hang limit
    // ---------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(negedge clock) begin
        // Capture the lanes while acknowledged and still strobed
        if (!bus.dtackN && !bus.mAsN) begin
            snapData <= bus.data;
            snapDs <= {bus.mDs1N, bus.mDs0N};
            snapLw <= bus.mLwordN;
            snapA1 <= bus.mAddr[1];
        end
        if (oddIack) sawIack <= 1'b1;
        if (oddRej) sawRej <= 1'b1;
        cycles++;
        if (cycles == 4000) begin
            errTotal++;
            $display("mismatch run expected end seen hang");
            results();
        end
    end
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function logic [31:0] wmask(input bpq_width_t w);
        return (w == BPQ_BYTE) ? 32'h0000_00FF : (w == BPQ_DOUBLE) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction
    // Right-aligned value on the lanes the width uses
    function logic [31:0] laneOf(input bpq_width_t w, input logic a0, input logic [31:0] d);
        if (w == BPQ_BYTE) return a0 ? {24'h0, d[7:0]} : {24'h0, d[15:8]};
        return d & wmask(w);
    endfunction
    function logic [31:0] modelRead(input bpq_width_t w, input int a);
        if (w == BPQ_BYTE) return {24'h0, mem[a]};
        if (w == BPQ_DOUBLE) return {16'h0, mem[a], mem[a+1]};
        return {mem[a], mem[a+1], mem[a+2], mem[a+3]};
    endfunction
    // One request through the master, checked on the wire and at the answer
    task req(input logic wr, input bpq_width_t w, input int a, input logic [31:0] d);
        logic bad;
        int n;
        bad = (w == BPQ_DOUBLE && a[0]) || (w == BPQ_QUAD && a[1:0] != 2'h0);
        reqValid = 1'b1;
        reqWrite = wr;
        reqWidth = w;
        reqAddr = a;
        reqData = d;
        @(posedge clock);
        @(negedge clock);
        reqValid = 1'b0;
        for (n = 0; n < 40 && rspDone !== 1'b1 && rspErr !== 1'b1; n++) @(negedge clock);
        check("rspErr", {31'h0, rspErr}, {31'h0, bad});
        check("rspDone", {31'h0, rspDone}, {31'h0, !bad});
        if (!bad) begin
            check("strobes", {30'h0, snapDs}, (w == BPQ_BYTE) ? (a[0] ? 2 : 1) : 0);
            check("lword", {31'h0, snapLw}, {31'h0, w != BPQ_QUAD});
            check("a01", {31'h0, snapA1}, {31'h0, a[1]});
            if (wr) begin
                check("wlane", laneOf(w, a[0], snapData), d & wmask(w));
                for (n = 0; n < (w == BPQ_BYTE ? 1 : w == BPQ_DOUBLE ? 2 : 4); n++)
                    mem[a+n] = d[8*((w == BPQ_BYTE ? 1 : w == BPQ_DOUBLE ? 2 : 4)-1-n) +: 8];
            end else begin
                check("rlane", laneOf(w, a[0], snapData), modelRead(w, a));
                check("rspData", rspData & wmask(w), modelRead(w, a));
            end
        end
        @(negedge clock);
    endtask
    // One cycle driven straight onto the second backplane
    task cyc2(input logic iackLow, input logic [1:0] ds, input logic lw, input logic wr,
        input logic [31:1] a, input logic [7:0] d, input logic expAck);
        logic got;
        int n;
        got = 1'b0;
        sawIack = 1'b0;
        sawRej = 1'b0;
        bus2.mIackO = !iackLow;
        bus2.mAddr = a;
        bus2.mLwordN = lw;
        bus2.mWriteN = !wr;
        bus2.mDataO = {24'hFFFFFF, d};
        bus2.mDataOe = wr;
        bus2.mAsN = 1'b0;
        @(negedge clock);
        {bus2.mDs1N, bus2.mDs0N} = ds;
        for (n = 0; n < 12 && !got; n++) begin
            @(negedge clock);
            got = (bus2.dtackN === 1'b0) || (bus2.sDataOe === 1'b1);
        end
        if (got && !wr) check("lane2", {24'h0, bus2.data[7:0]}, {24'h0, d});
        {bus2.mDs1N, bus2.mDs0N} = 2'h3;
        bus2.mAsN = 1'b1;
        bus2.mDataOe = 1'b0;
        for (n = 0; n < 12 && bus2.dtackN !== 1'b1; n++) @(negedge clock);
        check("ack2", {31'h0, got}, {31'h0, expAck});
        repeat (3) @(negedge clock);
    endtask
    task results();
        $display("checks %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        errTotal = 0;
        cmpCount = 0;
        cycles = 0;
        resetn = 1'b0;
        {reqValid, reqWrite, reqAddr, reqData} = '0;
        reqWidth = BPQ_BYTE;
        reqAm = BPQ_AM_EXT;
        rnd = 32'hE322;
        {sawIack, sawRej} = 2'h0;
        {bus2.mAsN, bus2.mDs0N, bus2.mDs1N, bus2.mLwordN, bus2.mWriteN} = 5'h1F;
        {bus2.mIackO, bus2.mIackOe, bus2.mDataOe} = 3'h6;
        bus2.mAm = BPQ_AM_EXT;
        bus2.mAddr = 31'h0;
        bus2.mDataO = 32'h0;
        repeat (20) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        // Fill every word, then each byte, pair and quad corner
        for (i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            req(1'b1, BPQ_QUAD, i * 4, rnd);
        end
        for (i = 0; i < 4; i++) begin
            req(1'b1, BPQ_BYTE, i, 32'h5A + i);
            req(1'b0, BPQ_BYTE, i, 32'h0);
            req(1'b0, BPQ_DOUBLE, i, 32'h0);
            req(1'b0, BPQ_QUAD, 60 + i, 32'h0);
        end
        // Random mix of widths, places and directions
        for (i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            req(rnd[8], bpq_width_t'(rnd[1:0] % 2'h3), int'(rnd[14:9]), lfsr(rnd));
        end
        // Odd-only slave: odd bytes answer, other widths refused, acknowledge cycle sat out
        cyc2(1'b0, 2'h2, 1'b1, 1'b1, 31'h0, 8'hA5, 1'b1);
        cyc2(1'b0, 2'h2, 1'b1, 1'b1, 31'h1, 8'h3C, 1'b1);
        cyc2(1'b0, 2'h2, 1'b1, 1'b0, 31'h0, 8'hA5, 1'b1);
        cyc2(1'b0, 2'h2, 1'b1, 1'b0, 31'h1, 8'h3C, 1'b1);
        cyc2(1'b0, 2'h1, 1'b1, 1'b0, 31'h0, 8'h00, 1'b0);
        check("rej", {31'h0, sawRej}, 32'h1);
        cyc2(1'b0, 2'h0, 1'b1, 1'b0, 31'h0, 8'h00, 1'b0);
        cyc2(1'b0, 2'h0, 1'b0, 1'b0, 31'h0, 8'h00, 1'b0);
        cyc2(1'b1, 2'h2, 1'b1, 1'b0, 31'h0, 8'h00, 1'b0);
        check("iack", {31'h0, sawIack}, 32'h1);
        // Foreign address size: no answer and no refusal report
        bus2.mAm = BPQ_AM_SHORT;
        cyc2(1'b0, 2'h2, 1'b1, 1'b0, 31'h0, 8'h00, 1'b0);
        check("rej0", {31'h0, sawRej}, 32'h0);
        results();
    end
endmodule // tb
